/* File: core/lock_counter.sv */
/*
  Digital lock detector: counts consecutive in-window comparisons.
  Assumes one comparison result per strobe from the phase detector.
*/
`timescale 1ns/1ns
module lock_counter
  import synth_ctrl_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic cmp_i,
  input wire logic in_window_i,
  input wire logic [CNT_W-1:0] need_i,
  input wire logic ref_lost_i,
  input wire logic loss_mode_i,
  output logic locked_o
);
  lock_state_e state_q;
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= LD_IDLE;
      cnt_q <= '0;
    end else if (clear_i || (loss_mode_i && ref_lost_i)) begin
      state_q <= LD_IDLE;
      cnt_q <= '0;
    end else if (cmp_i) begin
      case (state_q)
        LD_IDLE: begin
          cnt_q <= in_window_i ? CNT_W'(1) : '0;
          if (in_window_i) state_q <= LD_COUNT;
        end
        LD_COUNT: begin
          if (!in_window_i) begin
            state_q <= LD_IDLE;
            cnt_q <= '0;
          end else if (cnt_q + CNT_W'(1) >= need_i) begin
            state_q <= LD_LOCKED;
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        LD_LOCKED: begin
          if (!in_window_i) begin
            state_q <= LD_IDLE;
            cnt_q <= '0;
          end
        end
        default: begin
          state_q <= LD_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  assign locked_o = (state_q == LD_LOCKED);
endmodule // lock_counter

/* File: core/pin_sync.sv */
/*
  Three-stage synchroniser for one pin; output changes once stages two and three agree.
  Assumes a free-running clock and the synchronised reset.
*/
`timescale 1ns/1ns
module pin_sync (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule // pin_sync

/* File: core/synth_ctrl_bank.sv */
/*
  Control register bank of a fractional-N synthesizer: words 4 to 7, plus
  status read-back, output divider double buffering, lock detect and load sync.
  Assumes a host on the plain register port and a reference clock pin.
*/
// The register offsets and strobed register access were left to the implementer.
// What this block does
// RULE1 - Status pin level select: 0 means 1.8 V, 1 means 3.3 V.
// RULE2 - Detector polarity bit: 1 positive, 0 negative.
// RULE3 - Power-down bit enters power-down; contents stay.
// RULE4 - Power-down holds counters, stops oscillator, tristates pump, clears lock, mutes outputs.
// RULE5 - Pump tristate bit puts charge pump in high impedance.
// RULE6 - Divider reset bit holds both dividers and band select in reset.
// RULE7 - Host writes fixed reserved word exactly as given.
// RULE8 - Select 0110 loads output/bleed word, 0111 loads lock word.
// RULE9 - Gated bleed keeps bleed off until lock.
// RULE10 - Negative bleed bit enables constant negative bleed.
// RULE11 - Host writes reserved output word bits as documented.
// RULE12 - Output B carries fundamental when set, else duplicates A.
// RULE13 - Feedback select: 1 oscillator direct, 0 divider output.
// RULE14 - Divider field waits for word 0 when double buffering on.
// RULE15 - Eight-bit bleed magnitude, polarity bit selects sign.
// RULE16 - Mute until locked removes output stage supply until lock.
// RULE17 - Output B disabled by 1, output A enabled by 1.
// RULE18 - Two-bit power level fields for outputs B and A.
// RULE19 - Load sync aligns load strobe to chosen reference edge.
// RULE20 - Lock asserts after selected consecutive in-window cycles.
// RULE21 - Loss-of-lock mode detects reference removal.
// RULE22 - Lock window 5, 6, 8, 12 ns, or 2.9 ns fixed.
// RULE23 - Select 0100 loads the reference and control word.
// RULE24 - Double buffer enable bit in reference and control word.
// RULE25 - 32-bit words, low four bits select target, latched on load.
`timescale 1ns/1ns
`include "synth_ctrl_regs.svh"
module synth_ctrl_bank
  import synth_ctrl_pkg::*;
#(
  parameter int LOSS_TIMEOUT = 64,
  parameter int CNT_W = 12
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Reference and detector
  input wire logic ref_clk_i,
  input wire logic cmp_i,
  input wire logic in_window_i,
  // Analog controls
  output logic status_level_3v3_o,
  output logic detector_polarity_o,
  output logic vco_enable_o,
  output logic pump_tristate_o,
  output logic divider_reset_o,
  output logic bleed_enable_o,
  output logic bleed_polarity_o,
  output logic [7:0] bleed_magnitude_o,
  output logic negative_bleed_o,
  output logic out_b_fundamental_o,
  output logic feedback_direct_o,
  output logic [2:0] output_divider_o,
  output logic out_a_on_o,
  output logic out_b_on_o,
  output logic [1:0] out_a_power_level_o,
  output logic [1:0] out_b_power_level_o,
  output logic [7:0] lock_window_width_o,
  output logic lock_detect_o,
  output logic load_strobe_o
);
  logic rst1_q;
  logic rst_n;
  word_t ref_ctrl_q;
  word_t fixed_q;
  word_t out_bleed_q;
  word_t lock_sync_q;
  logic [2:0] div_active_q;
  logic ref_lvl;
  logic ref_lvl_q;
  logic locked;
  logic ref_lost_q;
  logic [7:0] ref_idle_q;
  logic pend_q;
  logic ld_pulse;
  logic [CNT_W-1:0] need;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] code);
    return a == code;
  endfunction

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst1_q <= 1'b1;
      rst_n <= rst1_q;
    end
  end

  pin_sync ref_sync (
    .clk_i(core_clk_i),
    .nrst_i(rst_n),
    .pin_i(ref_clk_i),
    .level_o(ref_lvl)
  );

  // Word loading; low nibble picks the target, power-down keeps loading
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_ctrl_q <= `RST_REF_CTRL;
      fixed_q <= `FIXED_RSVD_VALUE;
      out_bleed_q <= `RST_OUT_BLEED;
      lock_sync_q <= `RST_LOCK_SYNC;
    end else if (wr_i) begin // RULE25 RULE4 RULE3
      if (hit(wdata_i[3:0], `SEL_REF_CTRL)) ref_ctrl_q <= wdata_i; // RULE23
      if (hit(wdata_i[3:0], `SEL_FIXED_RSVD)) fixed_q <= wdata_i; // RULE7
      if (hit(wdata_i[3:0], `SEL_OUT_BLEED)) out_bleed_q <= wdata_i; // RULE8
      if (hit(wdata_i[3:0], `SEL_LOCK_SYNC)) lock_sync_q <= wdata_i; // RULE8
    end
  end

  // Divider field: immediate, or held until the next word 0
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_active_q <= 3'h0;
    end else if (wr_i && hit(wdata_i[3:0], `SEL_OUT_BLEED) && !ref_ctrl_q[`RC_DBL_BUF]) begin // RULE14 RULE24
      div_active_q <= wdata_i[`OB_DIV_LO+:3];
    end else if (wr_i && hit(wdata_i[3:0], `SEL_FREQ_INT) && ref_ctrl_q[`RC_DBL_BUF]) begin // RULE14
      div_active_q <= out_bleed_q[`OB_DIV_LO+:3];
    end
  end

  // Reference edge seen on either polarity; no edges for a while means lost
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_lvl_q <= 1'b0;
      ref_idle_q <= 8'h00;
      ref_lost_q <= 1'b0;
    end else begin
      ref_lvl_q <= ref_lvl;
      if (ref_lvl != ref_lvl_q) begin
        ref_idle_q <= 8'h00;
        ref_lost_q <= 1'b0;
      end else if (ref_idle_q >= 8'(LOSS_TIMEOUT)) begin
        ref_lost_q <= 1'b1; // RULE21
      end else begin
        ref_idle_q <= ref_idle_q + 8'h01;
      end
    end
  end

  // Load strobe: direct, or delayed to the selected reference edge
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else if (wr_i && lock_sync_q[`LD_SYNC_EN]) begin
      // Set wins: a write in the strobe cycle still waits for its own edge
      pend_q <= 1'b1; // RULE19
    end else if (ld_pulse) begin
      pend_q <= 1'b0;
    end
  end

  always_comb begin
    if (lock_sync_q[`LD_SYNC_EN]) begin // RULE19
      ld_pulse = pend_q && (lock_sync_q[`LD_SYNC_EDGE] ? (!ref_lvl && ref_lvl_q) : (ref_lvl && !ref_lvl_q));
    end else begin
      ld_pulse = wr_i;
    end
  end

  // Required count per two-bit field
  always_comb begin
    case (lock_sync_q[`LD_CNT_LO+:2]) // RULE20
      2'h0: need = CNT_W'(1024);
      2'h1: need = CNT_W'(2048);
      2'h2: need = CNT_W'(4096 - 1);
      default: need = CNT_W'(4096 - 1);
    endcase
  end

  lock_counter #(
    .CNT_W(CNT_W)
  ) lock_det (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .clear_i(ref_ctrl_q[`RC_POWERDOWN]), // RULE4
    .cmp_i(cmp_i),
    .in_window_i(in_window_i),
    .need_i(need),
    .ref_lost_i(ref_lost_q),
    .loss_mode_i(lock_sync_q[`LD_LOSS_MODE]), // RULE21
    .locked_o(locked)
  );

  // Analog control outputs, all registered
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_level_3v3_o <= 1'b0;
      detector_polarity_o <= 1'b0;
      vco_enable_o <= 1'b0;
      pump_tristate_o <= 1'b1;
      divider_reset_o <= 1'b1;
      bleed_enable_o <= 1'b0;
      bleed_polarity_o <= 1'b0;
      bleed_magnitude_o <= 8'h00;
      negative_bleed_o <= 1'b0;
      out_b_fundamental_o <= 1'b0;
      feedback_direct_o <= 1'b0;
      output_divider_o <= 3'h0;
      out_a_on_o <= 1'b0;
      out_b_on_o <= 1'b0;
      out_a_power_level_o <= 2'h0;
      out_b_power_level_o <= 2'h0;
      lock_window_width_o <= `WIN_5NS;
      lock_detect_o <= 1'b0;
      load_strobe_o <= 1'b0;
    end else begin
      status_level_3v3_o <= ref_ctrl_q[`RC_LEVEL]; // RULE1
      detector_polarity_o <= ref_ctrl_q[`RC_POLARITY]; // RULE2
      vco_enable_o <= !ref_ctrl_q[`RC_POWERDOWN]; // RULE4
      pump_tristate_o <= ref_ctrl_q[`RC_PUMP_TRI] || ref_ctrl_q[`RC_POWERDOWN]; // RULE5 RULE4
      divider_reset_o <= ref_ctrl_q[`RC_DIV_RESET] || ref_ctrl_q[`RC_POWERDOWN]; // RULE6 RULE4
      bleed_enable_o <= !out_bleed_q[`OB_GATED] || locked; // RULE9
      bleed_polarity_o <= out_bleed_q[`OB_BLEED_POL]; // RULE15
      bleed_magnitude_o <= out_bleed_q[`OB_BLEED_LO+:8]; // RULE15
      negative_bleed_o <= out_bleed_q[`OB_NEG_BLEED]; // RULE10
      out_b_fundamental_o <= out_bleed_q[`OB_B_FUND]; // RULE12
      feedback_direct_o <= out_bleed_q[`OB_FB_SEL]; // RULE13
      output_divider_o <= div_active_q;
      out_a_on_o <= out_bleed_q[`OB_A_EN] && !ref_ctrl_q[`RC_POWERDOWN]
        && (!out_bleed_q[`OB_MUTE] || locked); // RULE17 RULE16 RULE4
      out_b_on_o <= !out_bleed_q[`OB_B_DIS] && !ref_ctrl_q[`RC_POWERDOWN]
        && (!out_bleed_q[`OB_MUTE] || locked); // RULE17 RULE16 RULE4
      out_a_power_level_o <= out_bleed_q[`OB_A_PWR_LO+:2]; // RULE18
      out_b_power_level_o <= out_bleed_q[`OB_B_PWR_LO+:2]; // RULE18
      if (lock_sync_q[`LD_MODE]) begin // RULE22
        lock_window_width_o <= `WIN_2P9NS;
      end else begin
        case (lock_sync_q[`LD_WIN_LO+:2])
          2'h0: lock_window_width_o <= `WIN_5NS;
          2'h1: lock_window_width_o <= `WIN_6NS;
          2'h2: lock_window_width_o <= `WIN_8NS;
          default: lock_window_width_o <= `WIN_12NS;
        endcase
      end
      lock_detect_o <= locked;
      load_strobe_o <= ld_pulse;
    end
  end

  // Read-back by select nibble; status word on the spare code
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        `SEL_REF_CTRL: rdata_o <= ref_ctrl_q;
        `SEL_FIXED_RSVD: rdata_o <= fixed_q;
        `SEL_OUT_BLEED: rdata_o <= out_bleed_q;
        `SEL_LOCK_SYNC: rdata_o <= lock_sync_q;
        `SEL_STATUS: rdata_o <= {26'h0, ref_lost_q, div_active_q, pend_q, locked};
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

  // Write taken at one edge, register next edge, output one edge later
  sequence ref_write_s;
    wr_i && wdata_i[3:0] == `SEL_REF_CTRL;
  endsequence
  sequence bleed_write_s;
    wr_i && wdata_i[3:0] == `SEL_OUT_BLEED;
  endsequence
  sequence lock_write_s;
    wr_i && wdata_i[3:0] == `SEL_LOCK_SYNC;
  endsequence
  sequence word0_write_s;
    wr_i && wdata_i[3:0] == `SEL_FREQ_INT;
  endsequence
  sequence lock_rise_s;
    !locked ##1 locked;
  endsequence

  power_down_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE4
    ref_ctrl_q[`RC_POWERDOWN] |=> pump_tristate_o && divider_reset_o && !out_a_on_o && !out_b_on_o && !vco_enable_o)
    else $error("power-down effects missing");
  pd_lock_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE4
    ref_ctrl_q[`RC_POWERDOWN] |-> ##2 !lock_detect_o) else $error("lock kept in power-down");
  pump_tri_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE5
    ref_ctrl_q[`RC_PUMP_TRI] |=> pump_tristate_o) else $error("pump not tristated");
  div_reset_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE6
    ref_ctrl_q[`RC_DIV_RESET] |=> divider_reset_o) else $error("divider reset missing");
  ref_route_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE23
    ref_write_s |=> ref_ctrl_q == $past(wdata_i)) else $error("word 4 not loaded");
  word_route_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE8
    bleed_write_s |=> out_bleed_q == $past(wdata_i)) else $error("word 6 not loaded");
  lock_route_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE8
    lock_write_s |=> lock_sync_q == $past(wdata_i)) else $error("word 7 not loaded");
  level_sel_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE1
    ref_write_s |=> ##1 status_level_3v3_o == $past(wdata_i[`RC_LEVEL], 2)) else $error("level select wrong");
  polarity_sel_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE2
    ref_write_s |=> ##1 detector_polarity_o == $past(wdata_i[`RC_POLARITY], 2)) else $error("polarity wrong");
  gated_bleed_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE9
    out_bleed_q[`OB_GATED] && !locked |=> !bleed_enable_o) else $error("bleed before lock");
  mute_lock_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE16
    out_bleed_q[`OB_MUTE] && !locked |=> !out_a_on_o && !out_b_on_o) else $error("output on before lock");
  div_direct_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE14
    bleed_write_s ##0 !ref_ctrl_q[`RC_DBL_BUF] |=> div_active_q == $past(wdata_i[`OB_DIV_LO+:3]))
    else $error("divider not taken at once");
  dbl_buffer_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE14
    ref_ctrl_q[`RC_DBL_BUF] && !(wr_i && wdata_i[3:0] == `SEL_FREQ_INT) |=> $stable(div_active_q))
    else $error("divider changed without word 0");
  div_word0_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE24
    word0_write_s ##0 ref_ctrl_q[`RC_DBL_BUF] |=> div_active_q == $past(out_bleed_q[`OB_DIV_LO+:3]))
    else $error("divider not moved by word 0");
  win_fixed_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE22
    lock_sync_q[`LD_MODE] |=> lock_window_width_o == `WIN_2P9NS) else $error("window not 2.9 ns");
  strobe_direct_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE19
    wr_i && !lock_sync_q[`LD_SYNC_EN] |=> load_strobe_o) else $error("direct load strobe missing");
  strobe_wait_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE19
    lock_sync_q[`LD_SYNC_EN] && !pend_q |=> !load_strobe_o) else $error("load strobe without pending write");
  lock_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE20
    lock_rise_s |-> $past(cmp_i && in_window_i)) else $error("lock without in-window comparison");
  miss_drop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE20
    cmp_i && !in_window_i |=> !locked) else $error("lock kept after a miss");
  loss_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE21
    lock_sync_q[`LD_LOSS_MODE] && ref_lost_q |=> !locked) else $error("lock kept without reference");
  read_idle_a: assert property (@(posedge core_clk_i) disable iff (!rst_n) // RULE25
    !rd_i |=> rdata_o == 32'h00000000) else $error("read data outside read cycle");
endmodule // synth_ctrl_bank

/* File: core/synth_ctrl_pkg.sv */
/*
  Types shared by the synthesizer control register bank.
  Assumes the compile order package before modules.
*/
package synth_ctrl_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [2:0] {
    LD_IDLE = 3'h1,
    LD_COUNT = 3'h2,
    LD_LOCKED = 3'h4
  } lock_state_e;
endpackage

/* File: core/synth_ctrl_regs.svh */
/*
  Word select codes, field positions, reset values and timing counts of the
  synthesizer control register bank.
  Assumes inclusion once per compile unit by bare name.
*/
`ifndef SYNTH_CTRL_REGS_SVH
`define SYNTH_CTRL_REGS_SVH

// Word select codes in the low four bits
`define SEL_REF_CTRL 4'h4
`define SEL_FIXED_RSVD 4'h5
`define SEL_OUT_BLEED 4'h6
`define SEL_LOCK_SYNC 4'h7
`define SEL_FREQ_INT 4'h0
`define SEL_STATUS 4'hF

// Fixed reserved word value
`define FIXED_RSVD_VALUE 32'h00800025

// Reference and control word fields
`define RC_DIV_RESET 4
`define RC_PUMP_TRI 5
`define RC_POWERDOWN 6
`define RC_POLARITY 7
`define RC_LEVEL 8
`define RC_DBL_BUF 14

// Output and bleed word fields
`define OB_A_PWR_LO 4
`define OB_A_EN 6
`define OB_B_PWR_LO 7
`define OB_B_DIS 9
`define OB_MUTE 11
`define OB_BLEED_LO 13
`define OB_DIV_LO 21
`define OB_FB_SEL 24
`define OB_B_FUND 25
`define OB_NEG_BLEED 29
`define OB_GATED 30
`define OB_BLEED_POL 31

// Lock detect and sync word fields
`define LD_MODE 4
`define LD_WIN_LO 5
`define LD_LOSS_MODE 7
`define LD_CNT_LO 8
`define LD_SYNC_EN 25
`define LD_SYNC_EDGE 27

// Reset values
`define RST_REF_CTRL 32'h00000004
`define RST_OUT_BLEED 32'h14000006
`define RST_LOCK_SYNC 32'h00000007

// Lock windows in tenths of a nanosecond
`define WIN_5NS 8'h32
`define WIN_6NS 8'h3C
`define WIN_8NS 8'h50
`define WIN_12NS 8'h78
`define WIN_2P9NS 8'h1D

`endif

/* File: sim/host_model.sv */
/*
  Host controller model: loads 32-bit configuration words and reads words back.
  Assumes the bench calls its tasks from one process and the bank never stalls.
*/
`timescale 1ns/1ns
`include "synth_ctrl_regs.svh"
module host_model
  import synth_ctrl_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [3:0] addr_o,
  output word_t wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [31:0] rdata_i
);
  initial begin
    addr_o = 4'h0;
    wdata_o = 32'h00000000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Host keeps reserved fields legal whatever it is handed
  function automatic word_t legal(input word_t w);
    word_t v;
    v = w;
    if (w[3:0] == `SEL_FIXED_RSVD) v = `FIXED_RSVD_VALUE;
    if (w[3:0] == `SEL_OUT_BLEED) begin
      v[28:26] = 3'h5;
      v[12] = 1'b0;
      v[10] = 1'b0;
    end
    return v;
  endfunction
  // Strobe held high across a burst, so words go back to back
  task automatic load(input word_t ws[$]);
    foreach (ws[i]) begin
      @(posedge clk_i);
      wr_o <= 1'b1;
      wdata_o <= legal(ws[i]);
    end
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~wdata_o;
  endtask
  task automatic read(input logic [3:0] a, output word_t d, output word_t z);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    d = rdata_i;
    @(negedge clk_i);
    z = rdata_i;
  endtask
endmodule // host_model

/* File: sim/synth_ctrl_bank_tb_top.sv */
/*
  Self-checking bench of the synthesizer control register bank.
  Assumes the host model drives the register port; bench drives reference and detector.
*/
`timescale 1ns/1ns
module synth_ctrl_bank_tb_top
  import synth_ctrl_pkg::*;
;
  logic core_clk, nrst, wr, rd, ref_clk, ref_run, cmp, in_win;
  logic [3:0] addr;
  logic [1:0] ref_cnt;
  word_t wdata, rdata, w4, w6, w7, d, z;
  logic lvl, pol, vco, tri_o, drst, bl_en, bl_pol, neg, fund, fb, a_on, b_on, lock, lstb;
  logic [7:0] mag, win;
  logic [2:0] div;
  logic [1:0] a_pw, b_pw;
  int miscompares = 0;
  int compares = 0;
  int i, n;

  synth_ctrl_bank #(.LOSS_TIMEOUT(8), .CNT_W(12)) i_dut (.core_clk_i(core_clk), .nrst_i(nrst),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ref_clk_i(ref_clk),
    .cmp_i(cmp), .in_window_i(in_win), .status_level_3v3_o(lvl), .detector_polarity_o(pol),
    .vco_enable_o(vco), .pump_tristate_o(tri_o), .divider_reset_o(drst), .bleed_enable_o(bl_en),
    .bleed_polarity_o(bl_pol), .bleed_magnitude_o(mag), .negative_bleed_o(neg),
    .out_b_fundamental_o(fund), .feedback_direct_o(fb), .output_divider_o(div), .out_a_on_o(a_on),
    .out_b_on_o(b_on), .out_a_power_level_o(a_pw), .out_b_power_level_o(b_pw),
    .lock_window_width_o(win), .lock_detect_o(lock), .load_strobe_o(lstb));
  host_model i_host (.clk_i(core_clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Reference runs at an eighth of the core rate
  always @(posedge core_clk) begin
    ref_cnt <= ref_cnt + 2'h1;
    if (ref_run && ref_cnt == 2'h3) ref_clk <= ~ref_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic pulses(input int k, input logic inw);
    repeat (k) begin
      @(posedge core_clk);
      cmp <= 1'b1;
      in_win <= inw;
      @(posedge core_clk);
      cmp <= 1'b0;
    end
    settle();
  endtask
  task automatic strobes(input word_t w, input int exp);
    n = 0;
    i_host.load('{w});
    repeat (24) begin
      @(negedge core_clk);
      if (lstb === 1'b1) n++;
    end
    check("load_strobe", n, exp);
  endtask
  function automatic logic [7:0] exp_win(input word_t w);
    logic [7:0] t [4] = '{8'h32, 8'h3C, 8'h50, 8'h78};
    return w[4] ? 8'h1D : t[w[6:5]];
  endfunction

  initial begin
    nrst = 1'b0;
    ref_clk = 1'b0;
    ref_cnt = 2'h0;
    ref_run = 1'b1;
    cmp = 1'b0;
    in_win = 1'b0;
    i = $urandom(73);
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge core_clk);
    // Random control and output words, loaded back to back
    for (i = 0; i < 12; i++) begin
      w4 = $urandom;
      w4[3:0] = 4'h4;
      w4[6] = 1'b0;
      w4[14] = 1'b0;
      w6 = $urandom;
      w6[3:0] = 4'h6;
      w6[28:26] = 3'h5;
      {w6[30], w6[12:10]} = 4'h0;
      i_host.load('{w4, w6});
      settle();
      check("level", lvl, w4[8]);
      check("polarity", pol, w4[7]);
      check("tristate", tri_o, w4[5]);
      check("div_reset", drst, w4[4]);
      check("vco", vco, 1'b1);
      check("bleed_pol", bl_pol, w6[31]);
      check("bleed_mag", mag, w6[20:13]);
      check("neg_bleed", neg, w6[29]);
      check("fund", fund, w6[25]);
      check("fb", fb, w6[24]);
      check("divider", div, w6[23:21]);
      check("a_on", a_on, w6[6]);
      check("b_on", b_on, !w6[9]);
      check("pwr", {b_pw, a_pw}, {w6[8:7], w6[5:4]});
    end
    // Fixed word, read-back, and an unknown select code ignored
    z = $urandom;
    z[3:0] = 4'hB;
    i_host.load('{32'h00800025, z});
    i_host.read(4'h5, d, z);
    check("fixed_word", d, 32'h00800025);
    check("rdata_idle", z, 32'h0);
    i_host.read(4'h6, d, z);
    check("out_word", d, w6);
    // Every lock window code
    for (i = 0; i < 5; i++) begin
      w7 = 32'h04000007 | (i == 4 ? 32'h10 : i << 5);
      i_host.load('{w7});
      settle();
      check("window", win, exp_win(w7));
    end
    // Double buffered divider waits for word 0
    w6[23:21] = ~w6[23:21];
    i_host.load('{32'h00004004, w6});
    settle();
    check("div_held", div, 3'(~w6[23:21]));
    i_host.load('{32'h00000000});
    settle();
    check("div_moved", div, w6[23:21]);
    // Lock with mute and gated bleed; a miss restarts the count
    w6 = 32'h54000846;
    i_host.load('{32'h00000004, w6, 32'h04000007});
    settle();
    check("muted", a_on, 1'b0);
    check("gated", bl_en, 1'b0);
    pulses(600, 1'b1);
    pulses(1, 1'b0);
    pulses(600, 1'b1);
    check("no_lock", lock, 1'b0);
    pulses(430, 1'b1);
    check("lock", lock, 1'b1);
    check("unmuted", a_on, 1'b1);
    // Status word: only the lock flag set here
    i_host.read(4'hF, d, z);
    check("status", d, 32'h00000001);
    // Power-down: outputs off, registers kept and still loading
    i_host.load('{32'h00000044, w6 ^ 32'h00002000});
    settle();
    check("pd_vco", vco, 1'b0);
    check("pd_tri", tri_o, 1'b1);
    check("pd_lock", lock, 1'b0);
    check("pd_outs", {a_on, b_on}, 2'h0);
    check("pd_load", mag, 8'h01);
    i_host.read(4'h7, d, z);
    check("pd_keep", d, 32'h04000007);
    i_host.load('{32'h00000004});
    settle();
    check("pd_off", vco, 1'b1);
    // Loss-of-lock mode sees the reference vanish
    i_host.load('{32'h04000087});
    pulses(1030, 1'b1);
    check("lol_lock", lock, 1'b1);
    ref_run <= 1'b0;
    repeat (40) @(posedge core_clk);
    @(negedge core_clk);
    check("lol_lost", lock, 1'b0);
    ref_run <= 1'b1;
    // Load strobe free, synced on each edge, and stalled without reference
    strobes(32'h04000007, 1);
    strobes(32'h06000007, 1);
    strobes(32'h0E000007, 1);
    strobes(32'h06000007, 1);
    ref_run <= 1'b0;
    // Let edges already in the synchroniser drain first
    repeat (10) @(posedge core_clk);
    strobes(32'h00000004, 0);
    ref_run <= 1'b1;
    finish_test();
  end
  // Watchdog for a hung sequence
  initial begin
    #(50000 * 100);
    miscompares++;
    finish_test();
  end
endmodule // synth_ctrl_bank_tb_top
